/* File: core/power_state_control.sv */
// Purpose: Power-state sequencer: core-off, processor-only, radio, sleep
// Assumes: Enable and wake pins are asynchronous to sys_clk
// Notes:   Radio states are reachable only from the processor-on states
`timescale 1ns/100ps

// Notes on behaviour
// R1 - Processor stays powered whenever the radio runs.
// R2 - Five states: transmit, receive, processor-only, deep sleep, core-off.
// R3 - Enable pin low holds the device core-off; host keeps supply on.
// R4 - Enable pin held high moves core-off into processor-only.
// R5 - Transitions among radio, processor and sleep states follow software only; the code leaves deep sleep on the wake pin, not on a software request.
// R6 - Wake pin high blocks deep sleep regardless of software request.
// R7 - Wake pin low permits deep sleep only with no radio events pending.
// R8 - Wake pin activity wakes the device out of deep sleep.
// R9 - Host raises enable no earlier than supply and never floats it.
// R10 - Host lowers enable before the supply falls.
// R11 - Low-speed oscillator trusted only 10 us after enable rises.
// R12 - Board ties the always-on test input to ground.
// R13 - Enable and wake pins pass a two-stage synchroniser first.
module power_state_control
  import power_state_pkg::*;
#(
  parameter int SETTLE_CYC = OSC_SETTLE_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          chip_enable_pin,
  input  wire logic          always_on_wake_pin,
  input  wire logic          always_on_test_pin,
  input  wire sw_req_type    sw_req,
  input  wire logic          radio_events_pending,
  output logic               sw_req_ack,
  output dev_state_type      dev_state,
  output power_en_type       power_en,
  output logic               wake_event
);

  // Pin synchronisers; first stage read only by the second
  logic [1:0]    en_sync_q;
  logic [1:0]    wake_sync_q;
  logic          wake_prev_q;
  dev_state_type state_q;   // One of six states: the five device states of [R2] plus oscillator wait
  dev_state_type state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  power_en_type  pwr_q;
  power_en_type  pwr_d;
  logic          ack_q;
  logic          ack_d;
  logic          wake_q;

  wire en_s       = en_sync_q[1];
  wire wake_s     = wake_sync_q[1];
  wire wake_edge  = wake_s ^ wake_prev_q;
  wire settle_end = (cnt_q == CNT_W'(SETTLE_CYC - 1));
  wire proc_state = (state_q == ST_PROC_ONLY) || (state_q == ST_RADIO_TX)
                    || (state_q == ST_RADIO_RX);
  // Sleep allowed only with wake pin low and no radio work
  wire sleep_ok   = !wake_s && !radio_events_pending; // [R6] [R7]

  // Synchronise pins before any state decision
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_sync_q   <= SYNC_RST;
      wake_sync_q <= SYNC_RST;
      wake_prev_q <= 1'b0;
    end else begin
      en_sync_q   <= {en_sync_q[0], chip_enable_pin};    // [R13]
      wake_sync_q <= {wake_sync_q[0], always_on_wake_pin}; // [R13]
      wake_prev_q <= wake_s;
    end
  end

  // Next-state logic; enable low overrides every other request
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ack_d   = 1'b0;
    if (!en_s) begin
      state_d = ST_CORE_OFF;                              // [R3]
      cnt_d   = '0;
    end else begin
      case (state_q)
        ST_CORE_OFF: begin
          state_d = ST_OSC_WAIT;                          // [R4]
          cnt_d   = '0;
        end
        ST_OSC_WAIT: begin
          // Hold off until the slow oscillator has settled
          if (settle_end) begin
            state_d = ST_PROC_ONLY;                       // [R4] [R11]
          end else begin
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
        ST_PROC_ONLY, ST_RADIO_TX, ST_RADIO_RX: begin
          // Only software moves between the running states
          case (sw_req)                                   // [R5]
            REQ_PROC_ONLY: begin
              state_d = ST_PROC_ONLY;
              ack_d   = 1'b1;
            end
            REQ_RADIO_TX: begin
              state_d = ST_RADIO_TX;                      // [R1]
              ack_d   = 1'b1;
            end
            REQ_RADIO_RX: begin
              state_d = ST_RADIO_RX;                      // [R1]
              ack_d   = 1'b1;
            end
            REQ_DEEP_SLEEP: begin
              // Blocked request gets no ack and is not stored; software must ask again
              if (sleep_ok) begin                         // [R6] [R7]
                state_d = ST_DEEP_SLEEP;
                ack_d   = 1'b1;
              end
            end
            default: ;
          endcase
        end
        ST_DEEP_SLEEP: begin
          // Wake pin edge or high level brings the processor back
          if (wake_edge || wake_s) begin
            state_d = ST_PROC_ONLY;                       // [R8]
          end
        end
        default: state_d = ST_CORE_OFF;
      endcase
    end
  end

  // Domain enables decoded from the next state, registered
  always_comb begin
    pwr_d.core_on  = (state_d != ST_CORE_OFF);
    pwr_d.lsosc_ok = (state_d != ST_CORE_OFF) && (state_d != ST_OSC_WAIT);
    pwr_d.radio_on = (state_d == ST_RADIO_TX) || (state_d == ST_RADIO_RX);
    // Processor forced on whenever radio is on
    pwr_d.proc_on  = pwr_d.radio_on || (state_d == ST_PROC_ONLY); // [R1]
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_CORE_OFF;
      cnt_q   <= '0;
      pwr_q   <= '0;
      ack_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pwr_q   <= pwr_d;
      ack_q   <= ack_d;
      wake_q  <= (state_q == ST_DEEP_SLEEP) && (state_d == ST_PROC_ONLY);
    end
  end

  assign dev_state  = state_q;
  assign power_en   = pwr_q;
  assign sw_req_ack = ack_q;
  assign wake_event = wake_q;

  // Radio never on without processor
  radio_needs_proc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    power_en.radio_on |-> power_en.proc_on)                // [R1]
    else $error("radio on with processor off");

  // Enable low reaches core-off within synchroniser delay
  enable_low_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!chip_enable_pin)[*3] |=> dev_state == ST_CORE_OFF)   // [R3]
    else $error("enable low did not force core-off");

  // Core-off left for oscillator wait when synchronised enable is high
  leave_core_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dev_state == ST_CORE_OFF) && en_s |=> dev_state == ST_OSC_WAIT) // [R4]
    else $error("core-off not left with enable high");

  // Oscillator wait starts from a zero count with the oscillator not yet trusted
  osc_settle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(dev_state == ST_OSC_WAIT) |->
      !power_en.lsosc_ok && (cnt_q == '0))                 // [R11]
    else $error("oscillator trusted too early");

  // Oscillator wait never ends before the settle count is reached
  osc_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dev_state == ST_OSC_WAIT) && en_s && !settle_end
      |=> dev_state == ST_OSC_WAIT)                         // [R11]
    else $error("oscillator wait cut short");

  // Running-state changes only on a software request
  sw_only_moves_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    proc_state && en_s && (sw_req == REQ_NONE) |=> $stable(dev_state)) // [R5]
    else $error("running state changed without request");

  // Sleep never entered while wake pin high
  no_sleep_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    proc_state && wake_s |=> dev_state != ST_DEEP_SLEEP)   // [R6]
    else $error("deep sleep entered with wake pin high");

  // Sleep entered when allowed and requested
  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    proc_state && en_s && sw_req == REQ_DEEP_SLEEP && sleep_ok
      |=> dev_state == ST_DEEP_SLEEP ##0 sw_req_ack)        // [R7]
    else $error("allowed sleep request not taken");

  // Wake pin high leaves sleep next cycle
  wake_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dev_state == ST_DEEP_SLEEP && en_s && wake_s
      |=> dev_state == ST_PROC_ONLY ##0 wake_event)         // [R8]
    else $error("wake pin did not wake device");

endmodule : power_state_control

/* File: dv/host_model.sv */
// Purpose: Host model driving the enable, wake and test pins
// Assumes: Supply is up for the whole run; pins move at falling edges
// Notes:   Pins always hold a defined level, so none ever floats
`timescale 1ns/100ps
module host_model (
  input  wire logic sys_clk,
  output logic      chip_enable_pin,
  output logic      always_on_wake_pin,
  output logic      always_on_test_pin
);
  // Defined levels from time zero; enable low until supply is up
  initial begin
    chip_enable_pin    = 1'h0;
    always_on_wake_pin = 1'h0;
    always_on_test_pin = 1'h0;  // Board strap keeps test mode off
  end

  // Enable only moves while the supply is on, so order holds
  task automatic set_enable(input logic v);
    @(negedge sys_clk);
    chip_enable_pin = v;
  endtask : set_enable

  // Wake level is held until the next call
  task automatic set_wake(input logic v);
    @(negedge sys_clk);
    always_on_wake_pin = v;
  endtask : set_wake
endmodule : host_model

/* File: dv/test_power_state_control.sv */
// Purpose: Self-checking bench for the power-state sequencer
// Assumes: Settle count cut to 4 cycles to keep the run short
// Notes:   Pins come from host_model; bench drives the software side
`timescale 1ns/100ps
module test_power_state_control;
  import power_state_pkg::*;
  localparam int SETTLE = 4;
  logic          sys_clk, rst_n, en, wake, tpin, pending, ack, wev;
  sw_req_type    sw_req;
  dev_state_type st;
  power_en_type  pe;
  int            fail_count, comparisons, n;

  host_model host (.sys_clk(sys_clk), .chip_enable_pin(en),
    .always_on_wake_pin(wake), .always_on_test_pin(tpin));
  power_state_control #(.SETTLE_CYC(SETTLE)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .chip_enable_pin(en), .always_on_wake_pin(wake),
    .always_on_test_pin(tpin), .sw_req(sw_req),
    .radio_events_pending(pending), .sw_req_ack(ack), .dev_state(st),
    .power_en(pe), .wake_event(wev));

  // Free-running 200 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Every comparison is counted; a mismatch is printed at once
  task automatic note(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : note
  task automatic chk_state(input dev_state_type exp);
    note({1'h0, st}, {1'h0, exp});
  endtask : chk_state
  task automatic chk_en(input power_en_type exp);
    note(pe, exp);
  endtask : chk_en
  task automatic chk_flag(input logic got, input logic exp);
    note({3'h0, got}, {3'h0, exp});
  endtask : chk_flag

  task automatic results();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Bounded wait; running out counts a mismatch and ends the run
  task automatic wait_state(input dev_state_type exp);
    n = 0;
    while (st !== exp) begin
      @(negedge sys_clk);
      n++;
      if (n > 40) begin
        fail_count++;
        results();
      end
    end
  endtask : wait_state

  // Request stands for one edge; result is read at the next fall
  task automatic request(input sw_req_type r);
    @(negedge sys_clk);
    sw_req = r;
    @(negedge sys_clk);
    sw_req = REQ_NONE;
  endtask : request

  // Software-side levels change at once when called; these tasks wait for no falling edge
  task automatic set_pending(input logic v);
    pending = v;
  endtask : set_pending

  task automatic set_reset(input logic v);
    rst_n = v;
  endtask : set_reset

  task automatic test_power_up();
    repeat (10) @(negedge sys_clk);
    chk_state(ST_CORE_OFF);
    chk_en(4'h0);
    host.set_enable(1'h1);
    wait_state(ST_OSC_WAIT);
    chk_en(4'h8);
    wait_state(ST_PROC_ONLY);
    chk_flag(n >= SETTLE, 1'h1);
    chk_en(4'hd);
    $display("test_power_up done");
  endtask : test_power_up

  task automatic test_radio();
    request(REQ_RADIO_TX);
    chk_flag(ack, 1'h1);
    chk_state(ST_RADIO_TX);
    chk_en(4'hf);
    request(REQ_RADIO_RX);
    chk_state(ST_RADIO_RX);
    chk_en(4'hf);
    repeat (8) @(negedge sys_clk);
    chk_state(ST_RADIO_RX);
    request(REQ_PROC_ONLY);
    chk_state(ST_PROC_ONLY);
    $display("test_radio done");
  endtask : test_radio

  task automatic test_sleep();
    host.set_wake(1'h1);
    repeat (3) @(negedge sys_clk);
    request(REQ_DEEP_SLEEP);
    chk_flag(ack, 1'h0);
    chk_state(ST_PROC_ONLY);
    set_pending(1'h1);
    host.set_wake(1'h0);
    repeat (3) @(negedge sys_clk);
    request(REQ_DEEP_SLEEP);
    chk_state(ST_PROC_ONLY);
    set_pending(1'h0);
    request(REQ_DEEP_SLEEP);
    chk_flag(ack, 1'h1);
    chk_state(ST_DEEP_SLEEP);
    chk_flag(pe.proc_on | pe.radio_on, 1'h0);
    request(REQ_RADIO_TX);
    chk_state(ST_DEEP_SLEEP);
    $display("test_sleep done");
  endtask : test_sleep

  task automatic test_wake();
    host.set_wake(1'h1);
    wait_state(ST_PROC_ONLY);
    // Pulse stands in the first cycle of processor-only, not later
    chk_flag(wev, 1'h1);
    host.set_wake(1'h0);
    $display("test_wake done");
  endtask : test_wake

  task automatic test_enable_low();
    request(REQ_RADIO_TX);
    host.set_enable(1'h0);
    wait_state(ST_CORE_OFF);
    chk_flag(n <= 4, 1'h1);
    chk_en(4'h0);
    request(REQ_PROC_ONLY);
    chk_state(ST_CORE_OFF);
    $display("test_enable_low done");
  endtask : test_enable_low

  // Reset mid-run with the radio on, then a clean restart from the pins
  task automatic test_mid_reset();
    host.set_enable(1'h1);
    wait_state(ST_PROC_ONLY);
    request(REQ_RADIO_TX);
    chk_state(ST_RADIO_TX);
    set_reset(1'h0);
    repeat (3) @(negedge sys_clk);
    chk_state(ST_CORE_OFF);
    chk_en(4'h0);
    chk_flag(ack, 1'h0);
    set_reset(1'h1);
    wait_state(ST_OSC_WAIT);
    chk_flag(n >= 3, 1'h1);
    wait_state(ST_PROC_ONLY);
    chk_en(4'hd);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  // Reset for five cycles, then the scenarios in order
  initial begin
    set_reset(1'h0);
    sw_req = REQ_NONE;
    set_pending(1'h0);
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(negedge sys_clk);
    set_reset(1'h1);
    test_power_up();
    test_radio();
    test_sleep();
    test_wake();
    test_enable_low();
    test_mid_reset();
    results();
  end
endmodule : test_power_state_control

/* File: pkg/power_state_pkg.sv */
// Purpose: Shared constants and types for the device power-state control
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package power_state_pkg;

  // Device power states
  typedef enum logic [2:0] {
    ST_CORE_OFF,
    ST_OSC_WAIT,
    ST_PROC_ONLY,
    ST_RADIO_TX,
    ST_RADIO_RX,
    ST_DEEP_SLEEP
  } dev_state_type;

  // Software request codes
  typedef enum logic [2:0] {
    REQ_NONE,
    REQ_PROC_ONLY,
    REQ_RADIO_TX,
    REQ_RADIO_RX,
    REQ_DEEP_SLEEP
  } sw_req_type;

  // Decoded power domain enables
  typedef struct packed {
    logic core_on;
    logic proc_on;
    logic radio_on;
    logic lsosc_ok;
  } power_en_type;

  localparam int  CLK_PERIOD_PS   = 5000;
  localparam int  OSC_SETTLE_NS   = 10000;  // 10 us
  localparam int  OSC_SETTLE_CYC  =
    (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int  CNT_W           = 16;
  localparam logic [1:0] SYNC_RST = 2'h0;

endpackage : power_state_pkg
